// ===== hw/urm_pkg.sv
package urm_pkg;
  // ==========================================================
  // Register indices (byte address = 4 * index)
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_IEN  = 4'h1;
  localparam logic [3:0] IDX_IID  = 4'h2;
  localparam logic [3:0] IDX_LCR  = 4'h3;
  localparam logic [3:0] IDX_MCR  = 4'h4;
  localparam logic [3:0] IDX_LSR  = 4'h5;
  localparam logic [3:0] IDX_MSR  = 4'h6;
  localparam logic [3:0] IDX_SCR  = 4'h7;
  localparam logic [3:0] IDX_IST  = 4'h8;
  localparam logic [3:0] IDX_IMSK = 4'h9;
  // ==========================================================
  // Line control field positions
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN  = 3;
  localparam int LCR_EPS  = 4;
  localparam int LCR_FIX  = 5;
  localparam int LCR_SIL  = 6;
  localparam int LCR_DLAB = 7;
  // ==========================================================
  // Values after reset
  localparam logic [7:0]  LCR_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  // ==========================================================
  // Oversampling counts, in 16x ticks
  localparam logic [5:0] BIT_LAST  = 6'h0F;
  localparam logic [5:0] HALF_LAST = 6'h07;
  localparam logic [5:0] STOP1_T   = 6'h10;
  localparam logic [5:0] STOP15_T  = 6'h18;
  localparam logic [5:0] STOP2_T   = 6'h20;
  localparam logic [5:0] XSTOP15   = 6'h0B;
  localparam logic [5:0] XSTOP2    = 6'h0F;
  localparam logic [2:0] MIN_BITS  = 3'h4;
  // ==========================================================
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } urm_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_STOP2
  } urm_rx_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } urm_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } urm_apb_rsp_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] prdata;
    logic        slverr;
    logic [15:0] div;
    logic [15:0] bcnt;
    logic        tick;
    logic [7:0]  lcr;
    logic [3:0]  ien;
    logic [4:0]  mcr;
    logic [7:0]  scr;
    logic [7:0]  thr;
    logic        thr_full;
    urm_tx_t     tx_st;
    logic [7:0]  tx_sh;
    logic [7:0]  tx_word;
    logic [2:0]  tx_bit;
    logic [5:0]  tx_cnt;
    logic        tx_par;
    logic        tx_out;
    logic        rx_s1;
    logic        rx_s2;
    urm_rx_t     rx_st;
    logic [7:0]  rx_sh;
    logic [2:0]  rx_bit;
    logic [5:0]  rx_cnt;
    logic        rx_perr;
    logic        rx_ferr;
    logic [7:0]  rx_buffer;
    logic        dr;
    logic        oe;
    logic        pe;
    logic        fe;
    logic        bi;
    logic [2:0]  ist;
    logic [2:0]  imsk;
  } urm_state_t;
endpackage

// ===== hw/urm_uart.sv
`timescale 1ns/100ps
// Overview of operation
// - Divisor access clear: offset 0 writes transmit, reads received byte
// - Data bits travel least significant first on transmit and receive
// - Without FIFOs, identification bits 3 and 7 and status bit 7 read zero
// - Even select gives even ones count over data and parity, else odd
// - Parity sense does nothing unless parity enable is set
// - Transmitter puts the parity bit after last data bit, before stop
// - Receiver checks parity at the same position, right after data
// - Extra stop clear: one stop bit sent and checked
// - Extra stop set with five data bits: one and a half stop bits
// - Extra stop set with six to eight data bits: two stop bits
// - Length field 00..11 selects five to eight data bits
// - Divisor access set maps offsets 0 and 1 to divisor low and high
// - Fixed parity forces parity bit to inverse of even select
module urm_uart (
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire urm_pkg::urm_apb_req_t apb_i,
  output urm_pkg::urm_apb_rsp_t      apb_o,
  input  wire logic                  serial_in_i,
  output logic                       serial_out_o,
  output logic                       irq_o
);
  urm_pkg::urm_state_t s;
  urm_pkg::urm_state_t n;
  logic [1:0] len;
  logic [2:0] last_bit;
  logic [7:0] mask;
  logic [5:0] stop_t;
  logic [5:0] xstop;
  logic [3:0] idx;
  logic       hit;
  logic       acc;
  logic       commit;
  logic       dlab;
  logic [7:0] rx_al;
  logic [2:0] iid;
  logic [7:0] rd;
  logic       ev_rx;
  logic       ev_tx;
  logic       ev_err;
  logic       exp_par;

  // ==========================================================
  // Frame format decode
  // Length and stop count are shared by both directions
  always_comb begin
    len      = s.lcr[1:0];
    last_bit = urm_pkg::MIN_BITS + {1'b0, len};
    mask     = 8'hFF >> (2'h3 - len);
    if (!s.lcr[urm_pkg::LCR_STOP]) begin
      stop_t = urm_pkg::STOP1_T;
      xstop  = urm_pkg::XSTOP2;
    end else if (len == 2'h0) begin
      stop_t = urm_pkg::STOP15_T;
      xstop  = urm_pkg::XSTOP15;
    end else begin
      stop_t = urm_pkg::STOP2_T;
      xstop  = urm_pkg::XSTOP2;
    end
    rx_al = (s.rx_sh >> (2'h3 - len)) & mask;
  end

  // Parity of a word under the current line control
  function automatic logic par_of(input logic [7:0] d,
                                  input logic [7:0] m,
                                  input logic [7:0] lc);
    if (lc[urm_pkg::LCR_FIX]) begin
      par_of = ~lc[urm_pkg::LCR_EPS];
    end else begin
      par_of = (^(d & m)) ^ ~lc[urm_pkg::LCR_EPS];
    end
  endfunction

  // ==========================================================
  // Bus decode and read mux
  always_comb begin
    idx    = apb_i.paddr[5:2];
    hit    = (apb_i.paddr[1:0] == 2'h0) && (apb_i.paddr[11:6] == 6'h00)
             && (idx <= urm_pkg::IDX_IMSK);
    acc    = apb_i.psel && apb_i.penable;
    commit = acc && s.ack;
    dlab   = s.lcr[urm_pkg::LCR_DLAB];
    // Priority: line error, data ready, holding empty
    if ((s.oe | s.pe | s.fe | s.bi) && s.ien[2]) begin
      iid = 3'h6;
    end else if (s.dr && s.ien[0]) begin
      iid = 3'h4;
    end else if (!s.thr_full && s.ien[1]) begin
      iid = 3'h2;
    end else begin
      iid = 3'h1;
    end
    rd = 8'h00;
    if (idx == urm_pkg::IDX_DATA) begin
      rd = dlab ? s.div[7:0] : s.rx_buffer;
    end else if (idx == urm_pkg::IDX_IEN) begin
      rd = dlab ? s.div[15:8] : {4'h0, s.ien};
    end else if (idx == urm_pkg::IDX_IID) begin
      rd = {4'h0, 1'b0, iid};
    end else if (idx == urm_pkg::IDX_LCR) begin
      rd = s.lcr;
    end else if (idx == urm_pkg::IDX_MCR) begin
      rd = {3'h0, s.mcr};
    end else if (idx == urm_pkg::IDX_LSR) begin
      rd = {1'b0, !s.thr_full && (s.tx_st == urm_pkg::TX_IDLE),
            !s.thr_full, s.bi, s.fe, s.pe, s.oe, s.dr};
    end else if (idx == urm_pkg::IDX_SCR) begin
      rd = s.scr;
    end else if (idx == urm_pkg::IDX_IST) begin
      rd = {5'h00, s.ist};
    end else if (idx == urm_pkg::IDX_IMSK) begin
      rd = {5'h00, s.imsk};
    end
  end

  // ==========================================================
  // Next state: baud, transmitter, bus, receiver, events
  // Hardware sets are applied after bus clears so they win
  always_comb begin
    n      = s;
    ev_rx  = 1'b0;
    ev_tx  = 1'b0;
    ev_err = 1'b0;
    // Baud generator; divisor 0 behaves as 1
    n.tick = 1'b0;
    n.bcnt = s.bcnt + 16'h0001;
    if ((s.div <= 16'h0001) || (s.bcnt >= s.div - 16'h0001)) begin
      n.bcnt = 16'h0000;
      n.tick = 1'b1;
    end
    // Transmitter
    case (s.tx_st)
      urm_pkg::TX_IDLE: begin
        if (s.thr_full) begin
          n.tx_sh    = s.thr;
          n.tx_word  = s.thr;
          n.tx_par   = par_of(s.thr, mask, s.lcr);
          n.thr_full = 1'b0;
          n.tx_cnt   = 6'h00;
          n.tx_bit   = 3'h0;
          n.tx_st    = urm_pkg::TX_START;
          ev_tx      = 1'b1;
        end
      end
      urm_pkg::TX_START: begin
        if (s.tick) begin
          n.tx_cnt = s.tx_cnt + 6'h01;
          if (s.tx_cnt == urm_pkg::BIT_LAST) begin
            n.tx_cnt = 6'h00;
            n.tx_st  = urm_pkg::TX_DATA;
          end
        end
      end
      urm_pkg::TX_DATA: begin
        if (s.tick) begin
          n.tx_cnt = s.tx_cnt + 6'h01;
          if (s.tx_cnt == urm_pkg::BIT_LAST) begin
            n.tx_cnt = 6'h00;
            n.tx_sh  = {1'b0, s.tx_sh[7:1]};
            n.tx_bit = s.tx_bit + 3'h1;
            if (s.tx_bit == last_bit) begin
              n.tx_st = s.lcr[urm_pkg::LCR_PEN] ? urm_pkg::TX_PAR
                                                : urm_pkg::TX_STOP;
            end
          end
        end
      end
      urm_pkg::TX_PAR: begin
        if (s.tick) begin
          n.tx_cnt = s.tx_cnt + 6'h01;
          if (s.tx_cnt == urm_pkg::BIT_LAST) begin
            n.tx_cnt = 6'h00;
            n.tx_st  = urm_pkg::TX_STOP;
          end
        end
      end
      default: begin
        if (s.tick) begin
          n.tx_cnt = s.tx_cnt + 6'h01;
          if (s.tx_cnt >= stop_t - 6'h01) begin
            n.tx_cnt = 6'h00;
            n.tx_st  = urm_pkg::TX_IDLE;
          end
        end
      end
    endcase
    // APB: first access cycle latches read data, second completes
    n.ack = acc && !s.ack;
    if (acc && !s.ack) begin
      n.prdata = {24'h000000, rd};
      n.slverr = !hit;
    end
    if (commit && hit && apb_i.pwrite) begin
      if (idx == urm_pkg::IDX_DATA) begin
        if (dlab) begin
          n.div[7:0] = apb_i.pwdata[7:0];
        end else begin
          n.thr      = apb_i.pwdata[7:0];
          n.thr_full = 1'b1;
        end
      end else if (idx == urm_pkg::IDX_IEN) begin
        if (dlab) begin
          n.div[15:8] = apb_i.pwdata[7:0];
        end else begin
          n.ien = apb_i.pwdata[3:0];
        end
      end else if (idx == urm_pkg::IDX_LCR) begin
        n.lcr = apb_i.pwdata[7:0];
      end else if (idx == urm_pkg::IDX_MCR) begin
        n.mcr = apb_i.pwdata[4:0];
      end else if (idx == urm_pkg::IDX_SCR) begin
        n.scr = apb_i.pwdata[7:0];
      end else if (idx == urm_pkg::IDX_IST) begin
        n.ist = s.ist & ~apb_i.pwdata[2:0];
      end else if (idx == urm_pkg::IDX_IMSK) begin
        n.imsk = apb_i.pwdata[2:0];
      end
    end
    // Read side effects
    if (commit && hit && !apb_i.pwrite) begin
      if ((idx == urm_pkg::IDX_DATA) && !dlab) begin
        n.dr = 1'b0;
      end else if (idx == urm_pkg::IDX_LSR) begin
        n.oe = 1'b0;
        n.pe = 1'b0;
        n.fe = 1'b0;
        n.bi = 1'b0;
      end
    end
    // Receiver; first flop feeds only the second
    n.rx_s1 = serial_in_i;
    n.rx_s2 = s.rx_s1;
    case (s.rx_st)
      urm_pkg::RX_IDLE: begin
        if (!s.rx_s2) begin
          n.rx_cnt = 6'h00;
          n.rx_st  = urm_pkg::RX_START;
        end
      end
      urm_pkg::RX_START: begin
        if (s.tick) begin
          n.rx_cnt = s.rx_cnt + 6'h01;
          if (s.rx_cnt == urm_pkg::HALF_LAST) begin
            // A start shorter than half a bit is noise
            n.rx_cnt  = 6'h00;
            n.rx_bit  = 3'h0;
            n.rx_perr = 1'b0;
            n.rx_st   = s.rx_s2 ? urm_pkg::RX_IDLE : urm_pkg::RX_DATA;
          end
        end
      end
      urm_pkg::RX_DATA: begin
        if (s.tick) begin
          n.rx_cnt = s.rx_cnt + 6'h01;
          if (s.rx_cnt == urm_pkg::BIT_LAST) begin
            n.rx_cnt = 6'h00;
            n.rx_sh  = {s.rx_s2, s.rx_sh[7:1]};
            n.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == last_bit) begin
              n.rx_st = s.lcr[urm_pkg::LCR_PEN] ? urm_pkg::RX_PAR
                                                : urm_pkg::RX_STOP;
            end
          end
        end
      end
      urm_pkg::RX_PAR: begin
        if (s.tick) begin
          n.rx_cnt = s.rx_cnt + 6'h01;
          if (s.rx_cnt == urm_pkg::BIT_LAST) begin
            n.rx_cnt  = 6'h00;
            n.rx_perr = s.rx_s2 != par_of(rx_al, mask, s.lcr);
            n.rx_st   = urm_pkg::RX_STOP;
          end
        end
      end
      urm_pkg::RX_STOP: begin
        if (s.tick) begin
          n.rx_cnt = s.rx_cnt + 6'h01;
          if (s.rx_cnt == urm_pkg::BIT_LAST) begin
            n.rx_cnt  = 6'h00;
            n.rx_ferr = !s.rx_s2;
            n.rx_st   = urm_pkg::RX_STOP2;
          end
        end
      end
      default: begin // Second stop checked only with extra stop
        if (!s.lcr[urm_pkg::LCR_STOP] || (s.tick && s.rx_cnt >= xstop)) begin
          n.rx_st = urm_pkg::RX_IDLE;
          n.rx_buffer   = rx_al;
          n.oe    = s.dr | n.oe; // Unread byte lost
          n.dr    = 1'b1;
          n.pe    = s.rx_perr | n.pe;
          n.fe    = s.rx_ferr | n.fe
                    | !s.rx_s2 & s.lcr[urm_pkg::LCR_STOP];
          n.bi    = (s.rx_ferr && rx_al == 8'h00) | n.bi;
          ev_rx   = 1'b1;
          ev_err  = s.dr | s.rx_perr | s.rx_ferr;
        end else if (s.tick) begin
          n.rx_cnt = s.rx_cnt + 6'h01;
        end
      end
    endcase
    // Sticky events: set beats a same-cycle clear
    n.ist = n.ist | {ev_err, ev_tx, ev_rx};
    // Line level; silence forces a steady low
    if (n.tx_st == urm_pkg::TX_START) begin
      n.tx_out = 1'b0;
    end else if (n.tx_st == urm_pkg::TX_DATA) begin
      n.tx_out = n.tx_sh[0];
    end else if (n.tx_st == urm_pkg::TX_PAR) begin
      n.tx_out = n.tx_par;
    end else begin
      n.tx_out = 1'b1;
    end
    n.tx_out = n.tx_out & ~n.lcr[urm_pkg::LCR_SIL];
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s        <= '0;
      s.div    <= urm_pkg::DIV_RST;
      s.lcr    <= urm_pkg::LCR_RST;
      s.tx_out <= 1'b1;
      s.rx_s1  <= 1'b1;
      s.rx_s2  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign apb_o.prdata  = s.prdata;
  assign apb_o.pready  = acc && s.ack;
  assign apb_o.pslverr = acc && s.ack && s.slverr;
  assign serial_out_o  = s.tx_out;
  assign irq_o         = |(s.ist & s.imsk);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  always_comb begin
    exp_par = (^(s.tx_word & mask)) ^ s.tx_out;
  end

  a_rbr_read: assert property (
    commit && !apb_i.pwrite && idx == urm_pkg::IDX_DATA && !dlab
    |-> apb_o.prdata[7:0] == $past(s.rx_buffer))
    else $error("receive byte read mismatch");
  a_thr_write: assert property (
    commit && apb_i.pwrite && idx == urm_pkg::IDX_DATA && !dlab
    |=> s.thr_full || s.tx_st == urm_pkg::TX_START)
    else $error("transmit byte not taken");
  a_div_read: assert property (
    commit && !apb_i.pwrite && idx == urm_pkg::IDX_IEN && dlab
    |-> apb_o.prdata[7:0] == s.div[15:8])
    else $error("divisor high read mismatch");
  a_compat_zero: assert property (
    commit && !apb_i.pwrite && hit && (idx == urm_pkg::IDX_LSR
    || idx == urm_pkg::IDX_IID) |-> !apb_o.prdata[7] && !apb_o.prdata[3]
    || idx == urm_pkg::IDX_LSR && !apb_o.prdata[7])
    else $error("compatibility bit not zero");
  a_par_gate: assert property (
    s.tx_st != urm_pkg::TX_PAR ##1 s.tx_st == urm_pkg::TX_PAR
    |-> $past(s.tx_st) == urm_pkg::TX_DATA && s.lcr[urm_pkg::LCR_PEN])
    else $error("parity slot without enable");
  a_par_sense: assert property (
    s.tx_st == urm_pkg::TX_PAR && !s.lcr[urm_pkg::LCR_SIL]
    && !s.lcr[urm_pkg::LCR_FIX]
    |-> exp_par == ~s.lcr[urm_pkg::LCR_EPS])
    else $error("parity sense wrong");
  a_lsb_first: assert property (
    s.tx_st == urm_pkg::TX_DATA && !s.lcr[urm_pkg::LCR_SIL]
    |-> s.tx_out == s.tx_word[s.tx_bit])
    else $error("data bit order wrong");
  a_data_bits: assert property (
    s.tx_st == urm_pkg::TX_DATA ##1 s.tx_st != urm_pkg::TX_DATA
    |-> $past(s.tx_bit) == last_bit)
    else $error("data bit count wrong");
  a_stop_len: assert property (
    s.tx_st == urm_pkg::TX_STOP ##1 s.tx_st == urm_pkg::TX_IDLE
    |-> $past(s.tx_cnt) == stop_t - 6'h01)
    else $error("stop length wrong");
  a_baud_tick: assert property (
    s.tick && s.div > 16'h0001 |=> !s.tick)
    else $error("baud tick too frequent");

  c_tx_parity: cover property (s.tx_st == urm_pkg::TX_PAR);
  c_rx_done: cover property (s.rx_st == urm_pkg::RX_STOP2 ##1 s.dr);
  c_irq: cover property (!irq_o ##1 irq_o);
  c_long_stop: cover property (s.tx_st == urm_pkg::TX_STOP
                               && s.tx_cnt == 6'h17);
endmodule // urm_uart

// ===== bench/urm_peer.sv
`timescale 1ns/100ps
// ==========================================================
// Serial peer: watches the device's output, sends frames back
module urm_peer (
  input  wire logic clk_i,
  input  wire logic rx_line_i,
  output logic      tx_line_o
);
  int unsigned cyc;

  // Free-running count used to time frame starts
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
  end

  // Line idles high between frames, as a real link does
  initial begin
    cyc = 0;
    tx_line_o = 1'b1;
  end

  // ==========================================================
  // Capture one frame, sampling mid bit on the falling clock edge
  task automatic get(input int n, input logic pen, input int cpb,
                     output logic [7:0] data, output logic par,
                     output logic stop_ok, output int unsigned start);
    data = 8'h00;
    par = 1'b0;
    // A frame that never comes is ended by the bench watchdog
    do begin
      @(negedge clk_i);
    end while (rx_line_i !== 1'b0);
    start = cyc;
    repeat (cpb / 2) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (cpb) @(negedge clk_i);
      data[i] = rx_line_i;
    end
    if (pen) begin
      repeat (cpb) @(negedge clk_i);
      par = rx_line_i;
    end
    repeat (cpb) @(negedge clk_i);
    stop_ok = rx_line_i;
  endtask

  // ==========================================================
  // Send one frame; stop length given in clocks by the caller
  task automatic send(input logic [7:0] data, input int n,
                      input logic pen, input logic par, input int cpb,
                      input int stop_clk);
    // Edges only on the rising clock, so the start bit is a full bit long
    @(posedge clk_i);
    tx_line_o <= 1'b0;
    repeat (cpb) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      tx_line_o <= data[i];
      repeat (cpb) @(posedge clk_i);
    end
    if (pen) begin
      tx_line_o <= par;
      repeat (cpb) @(posedge clk_i);
    end
    tx_line_o <= 1'b1;
    repeat (stop_clk) @(posedge clk_i);
  endtask
endmodule // urm_peer

// ===== bench/urm_uart_tb.sv
`timescale 1ns/100ps
// ==========================================================
// Register, framing and interrupt tests over APB
module urm_uart_tb;
  localparam logic [3:0] DAT = urm_pkg::IDX_DATA;
  localparam logic [3:0] IEN = urm_pkg::IDX_IEN;
  localparam logic [3:0] LCR = urm_pkg::IDX_LCR;
  logic                  clk_i  = 1'b0;
  logic                  rstn_i = 1'b0;
  urm_pkg::urm_apb_req_t apb_i  = '0;
  urm_pkg::urm_apb_rsp_t apb_o;
  logic                  serial_in_i;
  logic                  serial_out_o;
  logic                  irq_o;
  int                    failures = 0;
  int                    checks   = 0;
  int                    cpb      = 16;
  logic [31:0]           rd;
  logic                  err;
  logic [7:0]            cfgs [8] = '{8'h00, 8'h05, 8'h0E, 8'h1B,
                                      8'h2C, 8'h3F, 8'h13, 8'h04};
  logic [7:0]            bads     = 8'h18;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  urm_uart urm_uart_i (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .apb_i        (apb_i),
    .apb_o        (apb_o),
    .serial_in_i  (serial_in_i),
    .serial_out_o (serial_out_o),
    .irq_o        (irq_o)
  );

  urm_peer urm_peer_i (
    .clk_i     (clk_i),
    .rx_line_i (serial_out_o),
    .tx_line_o (serial_in_i)
  );

  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One APB transfer; right after a rising edge pready and prdata still
  // show what stood at that edge, as the design only changes by NBA
  task automatic apb(input logic wr, input logic [3:0] idx,
                     input logic [7:0] wd);
    @(posedge clk_i);
    apb_i.psel    <= 1'b1;
    apb_i.penable <= 1'b0;
    apb_i.pwrite  <= wr;
    apb_i.paddr   <= {6'h00, idx, 2'h0};
    apb_i.pwdata  <= {24'h000000, wd};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge clk_i);
    end while (apb_o.pready !== 1'b1);
    rd  = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  // Expected parity over the masked data for a line setting
  function automatic logic par(input logic [7:0] d, input logic [7:0] lc);
    if (lc[5]) begin
      return ~lc[4];
    end
    return lc[4] ? ^d : ~^d;
  endfunction

  // ==========================================================
  // Two frames out back to back, one frame in; bad forces parity wrong
  task automatic run_cfg(input logic [7:0] lc, input logic [7:0] d0,
                         input logic [7:0] d1, input logic bad);
    int          n, stop_t, gap, sp, d;
    int unsigned s0, s1;
    logic [7:0]  g0, g1, m;
    logic        p0, p1, k0, k1, pen;
    n = 5 + lc[1:0];
    pen = lc[3];
    m = 8'hFF >> (8 - n);
    stop_t = !lc[2] ? 16 : (n == 5 ? 24 : 32);
    gap = (16 * (1 + n + pen) + stop_t) * cpb / 16;
    d = cpb / 16;
    apb(1'b1, LCR, lc);
    fork
      begin
        apb(1'b1, DAT, d0);
        apb(1'b1, DAT, d1);
      end
      begin
        urm_peer_i.get(n, pen, cpb, g0, p0, k0, s0);
        urm_peer_i.get(n, pen, cpb, g1, p1, k1, s1);
      end
    join
    check({24'h0, g0}, {24'h0, d0 & m});
    check({24'h0, g1}, {24'h0, d1 & m});
    if (pen) begin
      check({31'h0, p0}, {31'h0, par(d0 & m, lc)});
    end
    check({31'h0, k0}, 32'h1);
    // Start-to-start spacing exposes stop count and parity slot; the
    // first frame meets its first tick at any phase, a spread of d clocks
    sp = s1 - s0;
    check({31'h0, (sp + d >= gap + 2) && (sp <= gap + 1)}, 32'h1);
    urm_peer_i.send(d1, n, pen, par(d1 & m, lc) ^ bad, cpb,
                    stop_t * cpb / 16);
    apb(1'b0, urm_pkg::IDX_LSR, 8'h00);
    check({31'h0, rd[2]}, {31'h0, bad});
    check({31'h0, rd[0]}, 32'h1);
    check({31'h0, rd[7]}, 32'h0);
    check({30'h0, rd[6:5]}, 32'h3);
    apb(1'b0, DAT, 8'h00);
    check(rd, {24'h0, d1 & m});
    $display("test frame lcr=%h done", lc);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    apb(1'b0, LCR, 8'h00);
    check(rd, 32'h0);
    apb(1'b1, LCR, 8'h80);
    apb(1'b0, DAT, 8'h00);
    check(rd, 32'h1);
    apb(1'b1, IEN, 8'h12);
    apb(1'b0, IEN, 8'h00);
    check(rd, 32'h12);
    apb(1'b1, IEN, 8'h00);
    apb(1'b1, LCR, 8'h00);
    apb(1'b1, IEN, 8'h0F);
    apb(1'b0, IEN, 8'h00);
    check(rd, 32'h0F);
    apb(1'b1, urm_pkg::IDX_SCR, 8'h5A);
    apb(1'b0, urm_pkg::IDX_SCR, 8'h00);
    check(rd, 32'h5A);
    apb(1'b1, urm_pkg::IDX_MCR, 8'h1F);
    apb(1'b0, urm_pkg::IDX_MCR, 8'h00);
    check(rd, 32'h1F);
    apb(1'b0, 4'hA, 8'h00);
    check({31'h0, err}, 32'h1);
    apb(1'b0, urm_pkg::IDX_IID, 8'h00);
    check(rd & 32'h88, 32'h0);
    check(rd, 32'h2);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      run_cfg(cfgs[i], 8'hA5 ^ i[7:0], 8'h5A + i[7:0], bads[i]);
    end
    // Divisor of three stretches every bit to 48 clocks
    apb(1'b1, LCR, 8'h80);
    apb(1'b1, DAT, 8'h03);
    apb(1'b0, DAT, 8'h00);
    check(rd, 32'h3);
    apb(1'b1, LCR, 8'h00);
    cpb = 48;
    run_cfg(8'h1F, 8'hC3, 8'h96, 1'b0);
    apb(1'b1, urm_pkg::IDX_IMSK, 8'h00);
    repeat (2) @(negedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    apb(1'b0, urm_pkg::IDX_IST, 8'h00);
    check({31'h0, rd[0]}, 32'h1);
    apb(1'b1, urm_pkg::IDX_IMSK, 8'h01);
    repeat (2) @(negedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    apb(1'b1, urm_pkg::IDX_IST, 8'h01);
    repeat (2) @(negedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    $display("test interrupts done");
    // Silence holds the line low even with the transmitter idle
    apb(1'b1, LCR, 8'h40);
    repeat (2) @(negedge clk_i);
    check({31'h0, serial_out_o}, 32'h0);
    $display("test silence done");
    give_verdict();
  end

  // Watchdog: the tests need well under this many cycles
  initial begin
    repeat (80000) @(posedge clk_i);
    failures++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule // urm_uart_tb
